// ---- verilog/ivp_defs.svh ----
// Constants of the interrupt vector and priority unit: vector slots,
// source numbering, field widths and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IVP_DEFS_SVH
`define IVP_DEFS_SVH

// Source count and field widths
`define IVP_NUM_SRC      10
`define IVP_IDX_W        4
`define IVP_LVL_W        2
`define IVP_PC_W         20
`define IVP_PSW_W        8
`define IVP_VEC_W        16

// Default priorities (source index equals default priority)
`define IVP_SRC_WDT      4'h0
`define IVP_SRC_LVI      4'h1
`define IVP_SRC_PIN0     4'h2
`define IVP_SRC_SER2_TX  4'h8
`define IVP_SRC_SER2_RX  4'h9
`define IVP_NUM_PINS     6

// Fixed vector slots, one two-byte entry each
`define IVP_VEC_WDT      16'h0004
`define IVP_VEC_LVI      16'h0006
`define IVP_VEC_PIN0     16'h0008
`define IVP_VEC_PIN1     16'h000A
`define IVP_VEC_PIN2     16'h000C
`define IVP_VEC_PIN3     16'h000E
`define IVP_VEC_PIN4     16'h0010
`define IVP_VEC_PIN5     16'h0012
`define IVP_VEC_SER2_TX  16'h0014
`define IVP_VEC_SER2_RX  16'h0016
`define IVP_VEC_BREAK    16'h007E

// Odd byte of an entry and least urgent programmable level
`define IVP_ODD_BIT      16'h0001
`define IVP_LVL_LOWEST   2'h3

// Reset values
`define IVP_RST_PC       20'h0_0000
`define IVP_RST_VEC      16'h0000
`define IVP_RST_BYTE     8'h00

`endif

// ---- verilog/ivp_pkg.sv ----
// Types of the interrupt vector and priority unit.
// Assumes ivp_defs.svh is on the include path.
`include "ivp_defs.svh"

package ivp_pkg;

   // Sequencer states, Gray coded along the accept path
   typedef enum logic [2:0] {
      IVP_IDLE     = 3'b000,
      IVP_PUSH_PC2 = 3'b001,
      IVP_PUSH_PC1 = 3'b011,
      IVP_PUSH_PC0 = 3'b010,
      IVP_FETCH_LO = 3'b110,
      IVP_FETCH_HI = 3'b111,
      IVP_CAP_LO   = 3'b101,
      IVP_CAP_HI   = 3'b100
   } ivp_state_type;

   typedef logic [`IVP_NUM_SRC-1:0]             ivp_src_vec_type;
   typedef logic [`IVP_NUM_SRC*`IVP_LVL_W-1:0]  ivp_lvl_vec_type;
   typedef logic [`IVP_IDX_W-1:0]               ivp_idx_type;

endpackage

// ---- verilog/ivp_prio_pick.sv ----
// Priority picker: most urgent level first, then smallest index.
// Assumes requests and levels are already qualified by the caller.
`timescale 1ns/1ps
`default_nettype none

module ivp_prio_pick #(
   parameter int N   = 10,
   parameter int LW  = 2,
   parameter int IW  = 4
) (
   input  wire logic [N-1:0]    req,     // Qualified requests
   input  wire logic [N*LW-1:0] level,   // Level per source, 0 most urgent
   output logic                 found,   // Any request present
   output logic [IW-1:0]        idx      // Winning source index
);

   logic [LW-1:0] best;

   // Scan from the back so the smallest index wins a tie
   always_comb begin
      found = 1'b0;
      idx   = '0;
      best  = '1;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i] && (!found || level[i*LW +: LW] <= best)) begin
            found = 1'b1;
            idx   = IW'(i);
            best  = level[i*LW +: LW];
         end
      end
   end

endmodule

`default_nettype wire

// ---- verilog/ivp_top.sv ----
// Interrupt vector and priority unit: pending flags, arbitration,
// stack push of status and return address, and vector fetch.
// Assumes one clock, synchronous inputs, and a CPU that keeps the
// stack pointer and vector memory with a one-cycle read latency.
`include "ivp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ivp_top
   import ivp_pkg::*;
#(
   parameter int NUM_SRC = `IVP_NUM_SRC,
   parameter int LVL_W   = `IVP_LVL_W
) (
   input  wire logic                    CORE_CLK,            // Core clock
   input  wire logic                    RST_B,               // Reset, low
   input  wire logic                    WATCHDOG_INTERVAL_REQUEST, // Pulse
   input  wire logic                    VOLTAGE_DETECT_REQUEST,    // Pulse
   input  wire logic [`IVP_NUM_PINS-1:0] EXT_PIN_REQUEST,     // Edge pulses
   input  wire logic                    SERIAL2_ASYNC_TX_REQUEST,   // Pulse
   input  wire logic                    SERIAL2_CLOCKED_TX_REQUEST, // Pulse
   input  wire logic                    SERIAL2_TWOWIRE_TX_REQUEST, // Pulse
   input  wire logic                    SERIAL2_ASYNC_RX_REQUEST,   // Pulse
   input  wire logic                    SERIAL2_CLOCKED_RX_REQUEST, // Pulse
   input  wire logic                    SERIAL2_TWOWIRE_RX_REQUEST, // Pulse
   input  wire logic                    SOFTWARE_BREAK,      // Break pulse
   input  wire ivp_pkg::ivp_src_vec_type SRC_MASK,           // 1 masks
   input  wire ivp_pkg::ivp_lvl_vec_type SRC_LEVEL,          // Levels
   input  wire logic                    INT_ENABLE,          // Global enable
   input  wire logic                    INSN_BOUNDARY,       // Accept slot
   input  wire logic [`IVP_PC_W-1:0]    CPU_PC,              // Return PC
   input  wire logic [`IVP_PSW_W-1:0]   PROGRAM_STATUS_WORD, // Status word
   input  wire logic [7:0]              VEC_DATA,            // Read byte
   output logic                         BUSY,                // Sequence on
   output logic                         INT_ACK,             // Accept pulse
   output logic                         INT_ACK_BREAK,       // Break taken
   output ivp_pkg::ivp_idx_type         INT_ACK_ID,          // Accepted id
   output ivp_pkg::ivp_src_vec_type     PENDING,             // Flags
   output logic                         PUSH_STB,            // Push pulse
   output logic [7:0]                   PUSH_DATA,           // Push byte
   output logic                         VEC_RD,              // Read pulse
   output logic [`IVP_VEC_W-1:0]        VEC_ADDR,            // Read address
   output logic                         PC_LOAD,             // Branch pulse
   output logic [`IVP_PC_W-1:0]         PC_VALUE             // Handler PC
);

   // Whole state of the unit
   typedef struct packed {
      ivp_state_type            state;
      logic                     busy;
      ivp_src_vec_type          pend;
      logic                     brk_pend;
      logic [`IVP_PC_W-1:0]     ret_pc;
      logic [`IVP_VEC_W-1:0]    vec;
      logic [7:0]               lo;
      logic                     ack;
      logic                     ack_brk;
      ivp_idx_type              ack_id;
      logic                     push_stb;
      logic [7:0]               push_data;
      logic                     vec_rd;
      logic [`IVP_VEC_W-1:0]    vec_addr;
      logic                     pc_load;
      logic [`IVP_PC_W-1:0]     pc_value;
   } ivp_regs_type;

   ivp_regs_type    s_reg;
   ivp_regs_type    s_next;
   ivp_src_vec_type raw_req;
   ivp_src_vec_type qual_req;
   logic            win_found;
   ivp_idx_type     win_idx;

   // Hard-wired slot of each source, one entry apart
   function automatic logic [`IVP_VEC_W-1:0] slot_of(input ivp_idx_type id);
      case (id)
         4'h0:    slot_of = `IVP_VEC_WDT;
         4'h1:    slot_of = `IVP_VEC_LVI;
         4'h2:    slot_of = `IVP_VEC_PIN0;
         4'h3:    slot_of = `IVP_VEC_PIN1;
         4'h4:    slot_of = `IVP_VEC_PIN2;
         4'h5:    slot_of = `IVP_VEC_PIN3;
         4'h6:    slot_of = `IVP_VEC_PIN4;
         4'h7:    slot_of = `IVP_VEC_PIN5;
         4'h8:    slot_of = `IVP_VEC_SER2_TX;
         4'h9:    slot_of = `IVP_VEC_SER2_RX;
         default: slot_of = `IVP_VEC_WDT;
      endcase
   endfunction

   // Source events placed at their default priority index
   always_comb begin
      raw_req = '0;
      raw_req[`IVP_SRC_WDT] = WATCHDOG_INTERVAL_REQUEST;
      raw_req[`IVP_SRC_LVI] = VOLTAGE_DETECT_REQUEST;
      for (int p = 0; p < `IVP_NUM_PINS; p++) begin
         raw_req[int'(`IVP_SRC_PIN0) + p] = EXT_PIN_REQUEST[p];
      end
      raw_req[`IVP_SRC_SER2_TX] = SERIAL2_ASYNC_TX_REQUEST
                                | SERIAL2_CLOCKED_TX_REQUEST
                                | SERIAL2_TWOWIRE_TX_REQUEST;
      raw_req[`IVP_SRC_SER2_RX] = SERIAL2_ASYNC_RX_REQUEST
                                | SERIAL2_CLOCKED_RX_REQUEST
                                | SERIAL2_TWOWIRE_RX_REQUEST;
   end

   // Only unmasked pending flags compete
   assign qual_req = s_reg.pend & ~SRC_MASK;

   // Level first, then smallest default priority
   ivp_prio_pick #(
      .N   (NUM_SRC),
      .LW  (LVL_W),
      .IW  (`IVP_IDX_W)
   ) u_pick (
      .req   (qual_req),
      .level (SRC_LEVEL),
      .found (win_found),
      .idx   (win_idx)
   );

   // Next-state logic of the whole unit
   always_comb begin
      s_next          = s_reg;
      s_next.ack      = 1'b0;
      s_next.ack_brk  = 1'b0;
      s_next.push_stb = 1'b0;
      s_next.vec_rd   = 1'b0;
      s_next.pc_load  = 1'b0;
      case (s_reg.state)
         IVP_IDLE: begin
            if (INSN_BOUNDARY && (s_reg.brk_pend ||
                                  (INT_ENABLE && win_found))) begin
               s_next.ret_pc    = CPU_PC;
               s_next.busy      = 1'b1;
               s_next.ack       = 1'b1;
               s_next.push_stb  = 1'b1;
               s_next.push_data = PROGRAM_STATUS_WORD;
               s_next.state     = IVP_PUSH_PC2;
               if (s_reg.brk_pend) begin
                  s_next.ack_brk  = 1'b1;
                  s_next.brk_pend = 1'b0;
                  s_next.vec      = `IVP_VEC_BREAK;
                  s_next.ack_id   = '0;
               end else begin
                  s_next.ack_id   = win_idx;
                  s_next.vec      = slot_of(win_idx);
                  s_next.pend[win_idx] = 1'b0;
               end
            end
         end
         IVP_PUSH_PC2: begin
            s_next.push_stb  = 1'b1;
            s_next.push_data = {4'h0, s_reg.ret_pc[19:16]};
            s_next.state     = IVP_PUSH_PC1;
         end
         IVP_PUSH_PC1: begin
            s_next.push_stb  = 1'b1;
            s_next.push_data = s_reg.ret_pc[15:8];
            s_next.state     = IVP_PUSH_PC0;
         end
         IVP_PUSH_PC0: begin
            s_next.push_stb  = 1'b1;
            s_next.push_data = s_reg.ret_pc[7:0];
            s_next.state     = IVP_FETCH_LO;
         end
         IVP_FETCH_LO: begin
            s_next.vec_rd   = 1'b1;
            s_next.vec_addr = s_reg.vec;
            s_next.state    = IVP_FETCH_HI;
         end
         IVP_FETCH_HI: begin
            s_next.vec_rd   = 1'b1;
            s_next.vec_addr = s_reg.vec | `IVP_ODD_BIT;
            s_next.state    = IVP_CAP_LO;
         end
         IVP_CAP_LO: begin
            s_next.lo    = VEC_DATA;
            s_next.state = IVP_CAP_HI;
         end
         IVP_CAP_HI: begin
            s_next.pc_load  = 1'b1;
            s_next.busy     = 1'b0;
            s_next.pc_value = {4'h0, VEC_DATA, s_reg.lo};
            s_next.state    = IVP_IDLE;
         end
         default: begin
            s_next.state = IVP_IDLE;
            s_next.busy  = 1'b0;
         end
      endcase
      // New events win over the clear at acceptance
      s_next.pend = s_next.pend | raw_req;
      if (SOFTWARE_BREAK) begin
         s_next.brk_pend = 1'b1;
      end
   end

   // State register
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_reg <= '{state: IVP_IDLE, busy: 1'b0, pend: '0,
                    brk_pend: 1'b0,
                    ret_pc: `IVP_RST_PC, vec: `IVP_RST_VEC,
                    lo: `IVP_RST_BYTE, ack: 1'b0, ack_brk: 1'b0,
                    ack_id: '0, push_stb: 1'b0,
                    push_data: `IVP_RST_BYTE, vec_rd: 1'b0,
                    vec_addr: `IVP_RST_VEC, pc_load: 1'b0,
                    pc_value: `IVP_RST_PC};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign BUSY          = s_reg.busy;
   assign INT_ACK       = s_reg.ack;
   assign INT_ACK_BREAK = s_reg.ack_brk;
   assign INT_ACK_ID    = s_reg.ack_id;
   assign PENDING       = s_reg.pend;
   assign PUSH_STB      = s_reg.push_stb;
   assign PUSH_DATA     = s_reg.push_data;
   assign VEC_RD        = s_reg.vec_rd;
   assign VEC_ADDR      = s_reg.vec_addr;
   assign PC_LOAD       = s_reg.pc_load;
   assign PC_VALUE      = s_reg.pc_value;

endmodule

`default_nettype wire

// ---- test/ivp_top_chk.sv ----
// Port assertions of the interrupt vector and priority unit.
// Assumes bind to ivp_top and ivp_defs.svh on the include path.
`include "ivp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ivp_top_chk (
   input wire logic        CORE_CLK,                  // Clock
   input wire logic        RST_B,                     // Reset, low
   input wire logic        WATCHDOG_INTERVAL_REQUEST, // Source 0
   input wire logic [5:0]  EXT_PIN_REQUEST,           // Pin edges
   input wire logic [7:0]  PROGRAM_STATUS_WORD,       // Status word
   input wire logic [7:0]  VEC_DATA,                  // Read byte
   input wire logic        INT_ACK,                   // Accept pulse
   input wire logic        INT_ACK_BREAK,             // Break taken
   input wire logic [3:0]  INT_ACK_ID,                // Accepted id
   input wire logic [9:0]  PENDING,                   // Flags
   input wire logic        PUSH_STB,                  // Push pulse
   input wire logic [7:0]  PUSH_DATA,                 // Push byte
   input wire logic        VEC_RD,                    // Read pulse
   input wire logic [15:0] VEC_ADDR,                  // Read address
   input wire logic        PC_LOAD,                   // Branch pulse
   input wire logic [19:0] PC_VALUE                   // Handler PC
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   // Sequence timing and data
   chk_psw_first: assert property (
      INT_ACK |-> PUSH_STB && PUSH_DATA == $past(PROGRAM_STATUS_WORD))
      else $error("status word not pushed first");
   chk_even_first: assert property (
      INT_ACK |-> ##4 VEC_RD && !VEC_ADDR[0] ##1 VEC_RD && VEC_ADDR[0]
      ##1 !VEC_RD)
      else $error("vector bytes out of order");
   chk_vec_slot: assert property (
      INT_ACK |-> ##4 VEC_ADDR == ($past(INT_ACK_BREAK, 4) ?
      `IVP_VEC_BREAK : 16'h0004 + {11'h000, INT_ACK_ID, 1'b0}))
      else $error("wrong vector slot");
   chk_pc_load: assert property (
      INT_ACK |=> (!PC_LOAD)[*6] ##1 PC_LOAD)
      else $error("branch not on time");
   chk_pc_bytes: assert property (
      PC_LOAD |-> PC_VALUE == {4'h0, $past(VEC_DATA), $past(VEC_DATA, 2)})
      else $error("handler address wrong");
   chk_wdt_flag: assert property (
      WATCHDOG_INTERVAL_REQUEST |=> PENDING[0])
      else $error("watchdog flag not set");
   chk_pin_flag: assert property (
      |EXT_PIN_REQUEST |=> (PENDING[7:2] & $past(EXT_PIN_REQUEST))
      == $past(EXT_PIN_REQUEST))
      else $error("pin flag not set");
   chk_brk_id: assert property (
      INT_ACK_BREAK |-> INT_ACK && INT_ACK_ID == 4'h0)
      else $error("break ack wrong");
   chk_ack_gap: assert property (
      INT_ACK |=> (!INT_ACK)[*7])
      else $error("accept while busy");
endmodule

bind ivp_top ivp_top_chk ivp_top_chk_i (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B),
   .WATCHDOG_INTERVAL_REQUEST(WATCHDOG_INTERVAL_REQUEST),
   .EXT_PIN_REQUEST(EXT_PIN_REQUEST),
   .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .VEC_DATA(VEC_DATA),
   .INT_ACK(INT_ACK), .INT_ACK_BREAK(INT_ACK_BREAK),
   .INT_ACK_ID(INT_ACK_ID), .PENDING(PENDING), .PUSH_STB(PUSH_STB),
   .PUSH_DATA(PUSH_DATA), .VEC_RD(VEC_RD), .VEC_ADDR(VEC_ADDR),
   .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE));

`default_nettype wire

// ---- test/ivp_cpu_model.sv ----
// CPU side model: vector memory and instruction boundary slots.
// Assumes a one-cycle read latency and one clock with the unit.
`timescale 1ns/1ps
`default_nettype none

module ivp_cpu_model (
   input  wire logic        clk,      // Core clock
   input  wire logic        rst_b,    // Reset, low
   input  wire logic        vec_rd,   // Read pulse
   input  wire logic [15:0] vec_addr, // Read address
   output logic             boundary, // Accept slot
   output var logic [7:0]   vec_data  // Read byte
);
   logic [1:0] slot;

   // Byte of a handler entry, pattern churns when not read
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_data <= 8'h00;
         slot <= 2'h0;
      end else begin
         slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
         if (vec_rd)
            vec_data <= vec_addr[0] ? (vec_addr[7:0] - 8'h01) ^ 8'h3C
                                    : vec_addr[7:0] ^ 8'hA5;
         else
            vec_data <= ~vec_data;
      end
   end

   // Stall one cycle in three
   assign boundary = (slot != 2'h0);
endmodule

`default_nettype wire

// ---- test/ivp_top_bench.sv ----
// Testbench of the interrupt vector and priority unit.
// Assumes ivp_pkg, ivp_top, the model and the checker are compiled.
`include "ivp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) \
   begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end

module ivp_top_bench;
   import ivp_pkg::*;
   logic clk, rst_b, int_en, busy, ack, ack_brk, push_stb, vec_rd;
   logic pc_load, boundary;
   logic [14:0] ev;
   ivp_src_vec_type mask, pending;
   ivp_lvl_vec_type lvl;
   ivp_idx_type ack_id;
   logic [19:0] pc, pc_value;
   logic [7:0]  program_status_word, push_data, vec_data;
   logic [15:0] vec_addr;
   int n_mismatch, comparisons, cyc;

   ivp_top ivp_top_i (.CORE_CLK(clk), .RST_B(rst_b),
      .WATCHDOG_INTERVAL_REQUEST(ev[0]), .VOLTAGE_DETECT_REQUEST(ev[1]),
      .EXT_PIN_REQUEST(ev[7:2]), .SERIAL2_ASYNC_TX_REQUEST(ev[8]),
      .SERIAL2_CLOCKED_TX_REQUEST(ev[9]),
      .SERIAL2_TWOWIRE_TX_REQUEST(ev[10]),
      .SERIAL2_ASYNC_RX_REQUEST(ev[11]),
      .SERIAL2_CLOCKED_RX_REQUEST(ev[12]),
      .SERIAL2_TWOWIRE_RX_REQUEST(ev[13]), .SOFTWARE_BREAK(ev[14]),
      .SRC_MASK(mask), .SRC_LEVEL(lvl), .INT_ENABLE(int_en),
      .INSN_BOUNDARY(boundary), .CPU_PC(pc), .PROGRAM_STATUS_WORD(program_status_word),
      .VEC_DATA(vec_data), .BUSY(busy), .INT_ACK(ack),
      .INT_ACK_BREAK(ack_brk), .INT_ACK_ID(ack_id), .PENDING(pending),
      .PUSH_STB(push_stb), .PUSH_DATA(push_data), .VEC_RD(vec_rd),
      .VEC_ADDR(vec_addr), .PC_LOAD(pc_load), .PC_VALUE(pc_value));

   ivp_cpu_model ivp_cpu_model_i (.clk(clk), .rst_b(rst_b),
      .vec_rd(vec_rd), .vec_addr(vec_addr), .boundary(boundary),
      .vec_data(vec_data));

   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One-cycle event on input bit b
   task automatic pulse(input int b);
      ev = 15'h0001 << b;
      @(negedge clk);
      ev = 15'h0000;
      @(negedge clk);
   endtask

   // Follow one accept sequence and judge each step
   task automatic acc(input logic [3:0] id, input logic b);
      logic [15:0] v;
      int k;
      v = b ? `IVP_VEC_BREAK : 16'h0004 + {11'h000, id, 1'b0};
      k = 0;
      while (ack !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      `CHK("ack", 1'b1, ack)
      `CHK("ack id", id, ack_id)
      `CHK("break", b, ack_brk)
      `CHK("push psw", program_status_word, push_data)
      `CHK("busy", 1'b1, busy)
      `CHK("taken", 1'b0, pending[id])
      @(negedge clk);
      `CHK("push pc", {4'h0, pc[19:16]}, push_data)
      @(negedge clk);
      `CHK("push pc mid", pc[15:8], push_data)
      @(negedge clk);
      `CHK("push pc low", pc[7:0], push_data)
      `CHK("push stb", 1'b1, push_stb)
      @(negedge clk);
      `CHK("vector", v, vec_addr)
      repeat (3) @(negedge clk);
      `CHK("load", 1'b1, pc_load)
      `CHK("busy done", 1'b0, busy)
      `CHK("handler", {4'h0, v[7:0] ^ 8'h3C, v[7:0] ^ 8'hA5}, pc_value)
   endtask

   // Every source and serial variant alone
   task automatic t_each();
      for (int b = 0; b < 14; b++) begin
         pulse(b);
         acc((b < 8) ? b[3:0] : (b < 11) ? 4'h8 : 4'h9, 1'b0);
      end
      $display("test each source done");
   endtask

   // Level first, then default order
   task automatic t_prio();
      int_en = 1'b0;
      lvl = 20'h3_FF3F;
      pulse(0);
      pulse(3);
      pulse(11);
      `CHK("pending", 10'h209, pending)
      int_en = 1'b1;
      acc(4'h3, 1'b0);
      acc(4'h9, 1'b0);
      acc(4'h0, 1'b0);
      lvl = 20'h0_0000;
      $display("test priority done");
   endtask

   // Break with interrupts off, masked source held
   task automatic t_break();
      int_en = 1'b0;
      mask = 10'h002;
      program_status_word = 8'h5B;
      pc = 20'hF_0E28;
      pulse(1);
      pulse(14);
      acc(4'h0, 1'b1);
      int_en = 1'b1;
      repeat (12) @(negedge clk);
      `CHK("idle", 1'b0, busy)
      `CHK("held", 1'b1, pending[1])
      mask = 10'h000;
      acc(4'h1, 1'b0);
      $display("test break done");
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      int_en = 1'b1;
      ev = 15'h0000;
      mask = 10'h000;
      lvl = 20'h0_0000;
      pc = 20'h9_3C71;
      program_status_word = 8'hD2;
      n_mismatch = 0;
      comparisons = 0;
      cyc = 0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      t_each();
      t_prio();
      t_break();
      final_report();
   end
endmodule

`default_nettype wire
